// ---- include/tpic_pkg.sv ----
// constants for the pulse interval capture timer channel
package tpic_pkg;
  localparam int TPIC_ADDR_W = 8;
  localparam int TPIC_DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] TPIC_OFF_TRIG = 8'h00;
  localparam logic [7:0] TPIC_OFF_MODE = 8'h04;
  localparam logic [7:0] TPIC_OFF_STAT = 8'h08;
  localparam logic [7:0] TPIC_OFF_COUNT = 8'h0C;
  localparam logic [7:0] TPIC_OFF_DATA = 8'h10;
  localparam logic [7:0] TPIC_OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] TPIC_OFF_IRQ_MASK = 8'h18;
  // trigger register bits, write one to act, read as zero
  localparam int TPIC_TRIG_START = 0;
  localparam int TPIC_TRIG_STOP = 1;
  localparam int TPIC_TRIG_UP_START = 2;
  localparam int TPIC_TRIG_UP_STOP = 3;
  // mode register fields
  localparam int TPIC_MODE_EDGE_LSB = 0;
  localparam int TPIC_MODE_SPLIT = 2;
  localparam logic [2:0] TPIC_MODE_RST = 3'h1;
  // status register bits
  localparam int TPIC_STAT_EN = 0;
  localparam int TPIC_STAT_UP_EN = 1;
  // interrupt status and mask bit
  localparam int TPIC_IRQ_CAPTURE = 0;
  localparam logic TPIC_MASK_RST = 1'b0;
  // valid edge codes
  localparam logic [1:0] TPIC_EDGE_FALL = 2'h0;
  localparam logic [1:0] TPIC_EDGE_RISE = 2'h1;
  localparam logic [1:0] TPIC_EDGE_BOTH = 2'h2;
  typedef enum logic [1:0] {TPIC_IDLE, TPIC_ARMED, TPIC_COUNTING} tpic_state_t;
endpackage : tpic_pkg

// ---- rtl/tpic_edge_det.sv ----
// pin synchroniser and valid edge detector
`timescale 1ns/1ps
module tpic_edge_det
  import tpic_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // pin and edge selection
  input wire logic pin_in,
  input wire logic [1:0] edge_sel_in,
  // result
  output logic valid_edge_out
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  wire rise = sync_ff & ~prev_ff;
  wire fall = ~sync_ff & prev_ff;
  // reserved code 3 behaves as rising
  wire nxt_valid_edge = (edge_sel_in == TPIC_EDGE_FALL) ? fall :
                        (edge_sel_in == TPIC_EDGE_BOTH) ? (rise | fall) : rise;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
      valid_edge_out <= 1'b0;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
      valid_edge_out <= nxt_valid_edge;
    end
  end
endmodule : tpic_edge_det

// ---- rtl/tpic_channel.sv ----
// one timer channel measuring input pulse intervals by capture
`timescale 1ns/1ps
module tpic_channel
  import tpic_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter bit SPLIT_EN = 1'b1
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // register port
  input wire logic [TPIC_ADDR_W-1:0] addr_in,
  input wire logic [TPIC_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [TPIC_DATA_W-1:0] rdata_out,
  // pin
  input wire logic channel_timer_input_in,
  // status and events
  output logic channel_enable_status_out,
  output logic upper_half_enable_status_out,
  output logic channel_capture_interrupt_out,
  output logic irq_out
);
  localparam int HALF_W = CNT_W / 2;

  if (CNT_W < 2 || CNT_W > TPIC_DATA_W || (CNT_W % 2) != 0)
  begin : g_bad_width
    $error("tpic_channel: CNT_W must be even and between 2 and 32");
  end

  tpic_state_t state_ff;
  tpic_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] data_ff;
  logic [2:0] mode_ff;
  logic up_run_ff;
  logic irq_stat_ff;
  logic irq_mask_ff;
  logic valid_edge;

  // address decode and write strobes
  wire wr_trig = wr_in && addr_in == TPIC_OFF_TRIG;
  wire wr_mode = wr_in && addr_in == TPIC_OFF_MODE;
  wire wr_data = wr_in && addr_in == TPIC_OFF_DATA;
  wire wr_irq_stat = wr_in && addr_in == TPIC_OFF_IRQ_STAT;
  wire wr_irq_mask = wr_in && addr_in == TPIC_OFF_IRQ_MASK;
  wire start_trig = wr_trig && wdata_in[TPIC_TRIG_START];
  wire stop_trig = wr_trig && wdata_in[TPIC_TRIG_STOP];
  wire split = SPLIT_EN && mode_ff[TPIC_MODE_SPLIT];
  wire up_start = split && wr_trig && wdata_in[TPIC_TRIG_UP_START];
  wire up_stop = wr_trig && wdata_in[TPIC_TRIG_UP_STOP];
  wire [1:0] edge_sel = mode_ff[TPIC_MODE_EDGE_LSB +: 2];

  tpic_edge_det u_edge (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pin_in(channel_timer_input_in),
    .edge_sel_in(edge_sel),
    .valid_edge_out(valid_edge)
  );

  wire counting = state_ff == TPIC_COUNTING;
  // stop beats a start written in the same cycle
  wire capture = counting && valid_edge && !stop_trig && !start_trig;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      TPIC_IDLE:
        if (start_trig && !stop_trig)
          nxt_state = TPIC_ARMED;
      TPIC_ARMED:
        if (stop_trig)
          nxt_state = TPIC_IDLE;
        else if (valid_edge && !start_trig)
          nxt_state = TPIC_COUNTING;
      TPIC_COUNTING:
        if (stop_trig)
          nxt_state = TPIC_IDLE;
        else if (start_trig)
          nxt_state = TPIC_ARMED;
      default:
        nxt_state = TPIC_IDLE;
    endcase
  end

  // lower part: whole counter, or only the low half when split
  wire [CNT_W-1:0] cnt_inc = cnt_ff + 1'b1;
  wire [HALF_W-1:0] lo_inc = cnt_ff[HALF_W-1:0] + 1'b1;
  wire [CNT_W-1:0] run_inc = split ? {cnt_ff[CNT_W-1:HALF_W], lo_inc} : cnt_inc;
  wire lo_clear = (start_trig && !stop_trig) || capture;
  wire [CNT_W-1:0] lo_next = lo_clear ? '0 : counting ? run_inc : cnt_ff;
  // upper half runs on its own triggers only in split mode
  wire [HALF_W-1:0] hi_inc = cnt_ff[CNT_W-1:HALF_W] + 1'b1;
  wire [HALF_W-1:0] hi_next = up_start ? '0 : up_run_ff ? hi_inc : cnt_ff[CNT_W-1:HALF_W];
  wire [CNT_W-1:0] nxt_cnt = split ? {hi_next, lo_next[HALF_W-1:0]} : lo_next;
  wire nxt_up_run = split && (up_start || (up_run_ff && !up_stop));
  // capture beats a software write of the data register
  wire [CNT_W-1:0] cap_val = split ? {data_ff[CNT_W-1:HALF_W], cnt_ff[HALF_W-1:0]} : cnt_ff;
  wire [CNT_W-1:0] nxt_data = capture ? cap_val : wr_data ? wdata_in[CNT_W-1:0] : data_ff;
  // a new capture wins over a write-one clear in the same cycle
  wire nxt_irq_stat = capture || (irq_stat_ff && !(wr_irq_stat && wdata_in[TPIC_IRQ_CAPTURE]));
  wire nxt_irq_mask = wr_irq_mask ? wdata_in[TPIC_IRQ_CAPTURE] : irq_mask_ff;
  wire [2:0] nxt_mode = wr_mode ? wdata_in[2:0] : mode_ff;
  wire nxt_en = nxt_state != TPIC_IDLE;

  // read selection; the count has no write path at all
  wire [TPIC_DATA_W-1:0] rd_mux =
    (addr_in == TPIC_OFF_MODE) ? TPIC_DATA_W'(mode_ff) :
    (addr_in == TPIC_OFF_STAT) ? TPIC_DATA_W'({up_run_ff, state_ff != TPIC_IDLE}) :
    (addr_in == TPIC_OFF_COUNT) ? TPIC_DATA_W'(cnt_ff) :
    (addr_in == TPIC_OFF_DATA) ? TPIC_DATA_W'(data_ff) :
    (addr_in == TPIC_OFF_IRQ_STAT) ? TPIC_DATA_W'(irq_stat_ff) :
    (addr_in == TPIC_OFF_IRQ_MASK) ? TPIC_DATA_W'(irq_mask_ff) : '0;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= TPIC_IDLE;
      cnt_ff <= '0;
      data_ff <= '0;
      mode_ff <= TPIC_MODE_RST;
      up_run_ff <= 1'b0;
      irq_stat_ff <= 1'b0;
      irq_mask_ff <= TPIC_MASK_RST;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      data_ff <= nxt_data;
      mode_ff <= nxt_mode;
      up_run_ff <= nxt_up_run;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // outputs all come from flops; the status ones load the next state, so they match the state flops in the same cycle
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_out <= '0;
      channel_enable_status_out <= 1'b0;
      upper_half_enable_status_out <= 1'b0;
      channel_capture_interrupt_out <= 1'b0;
      irq_out <= 1'b0;
    end
    else
    begin
      rdata_out <= rd_in ? rd_mux : '0;
      channel_enable_status_out <= nxt_en;
      upper_half_enable_status_out <= nxt_up_run;
      channel_capture_interrupt_out <= capture;
      irq_out <= nxt_irq_stat && nxt_irq_mask;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  sequence s_edge_while_counting;
    counting && valid_edge && !wr_trig;
  endsequence

  sequence s_count_restarts;
    ##1 cnt_ff[HALF_W-1:0] == '0 ##1 (!counting || cnt_ff[HALF_W-1:0] != '0 || valid_edge);
  endsequence

  a_start_clears_count: assert property (
    start_trig && !stop_trig |=> cnt_ff[HALF_W-1:0] == '0 && state_ff == TPIC_ARMED)
    else $error("start trigger did not clear and arm the channel");

  a_armed_waits_edge: assert property (
    state_ff == TPIC_ARMED && !valid_edge && !wr_trig |=> state_ff == TPIC_ARMED && $stable(cnt_ff[HALF_W-1:0]))
    else $error("armed channel counted before a valid edge");

  a_edge_starts_count: assert property (
    state_ff == TPIC_ARMED && valid_edge && !wr_trig |=> counting ##1 cnt_ff[HALF_W-1:0] == 1)
    else $error("valid edge did not start counting");

  a_capture_data: assert property (
    s_edge_while_counting |=> data_ff[HALF_W-1:0] == $past(cnt_ff[HALF_W-1:0]))
    else $error("capture did not store the count");

  a_capture_restarts: assert property (
    s_edge_while_counting |-> s_count_restarts)
    else $error("count not restarted after capture");

  a_capture_irq: assert property (
    s_edge_while_counting |=> channel_capture_interrupt_out && irq_stat_ff)
    else $error("capture interrupt missing");

  a_count_read_only: assert property (
    state_ff == TPIC_IDLE && !up_run_ff && !wr_trig |=> $stable(cnt_ff))
    else $error("count changed while the channel was stopped");

  a_data_write: assert property (
    wr_data && !capture |=> data_ff == $past(wdata_in[CNT_W-1:0]))
    else $error("data register write lost");

  // status flops mirror the next state, so check them one cycle on; a back to back start may follow
  a_stop_halts: assert property (
    stop_trig |=> state_ff == TPIC_IDLE && !channel_enable_status_out)
    else $error("stop trigger did not halt the channel");

  a_upper_start: assert property (
    up_start |=> up_run_ff && cnt_ff[CNT_W-1:HALF_W] == '0 && upper_half_enable_status_out)
    else $error("upper half did not start");

  // outside split mode the upper bits belong to the full counter and keep moving
  a_upper_stop: assert property (
    split && up_stop && !up_start |=> !up_run_ff && !upper_half_enable_status_out
      and (split && !wr_trig |=> $stable(cnt_ff[CNT_W-1:HALF_W])))
    else $error("upper half status or count wrong after stop");

  a_rising_only: assert property (
    edge_sel == TPIC_EDGE_RISE && $fell(u_edge.sync_ff) |=> !valid_edge)
    else $error("falling edge accepted in rising edge mode");
endmodule : tpic_channel

// ---- test/tpic_pulse_src.sv ----
// pulse source model driving the channel timer input pin
`timescale 1ns/1ps
module tpic_pulse_src
(
  // clock
  input wire logic clk_sys_in,
  // control
  input wire logic go_in,
  input wire logic [7:0] gap_in,
  // pin
  output logic pin_out
);
  logic [7:0] cnt_ff;
  initial pin_out = 1'b0;
  initial cnt_ff = 8'h00;
  // the pin keeps its level between bursts, as a real source would
  always @(posedge clk_sys_in)
  begin
    if (!go_in)
      cnt_ff <= 8'h00;
    else if (cnt_ff + 8'h01 >= gap_in)
    begin
      cnt_ff <= 8'h00;
      pin_out <= ~pin_out;
    end
    else
      cnt_ff <= cnt_ff + 8'h01;
  end
endmodule : tpic_pulse_src

// ---- test/tb_timer_channel_pulse_interval_capture.sv ----
// self-checking bench for the pulse interval capture channel
`timescale 1ns/1ps
module tb_timer_channel_pulse_interval_capture
  import tpic_pkg::*;
;
  logic clk, rst, wr, rd, rd_d, pin, go, en_st, up_st, cap, irq;
  logic [7:0] addr, gap;
  logic [31:0] wdata, rdata, last;
  logic [31:0] q[$];
  int n_mismatch = 0;
  int comparisons = 0;
  // reserved code 3 must act as rising
  logic [1:0] modes[4] = '{TPIC_EDGE_FALL, TPIC_EDGE_RISE, TPIC_EDGE_BOTH, 2'h3};

  tpic_channel u_dut (.clk_sys_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .channel_timer_input_in(pin), .channel_enable_status_out(en_st),
    .upper_half_enable_status_out(up_st), .channel_capture_interrupt_out(cap), .irq_out(irq));
  tpic_pulse_src u_src (.clk_sys_in(clk), .go_in(go), .gap_in(gap), .pin_out(pin));

  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // strobes drop for one cycle between accesses so no signal is driven twice per step
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rreg

  task automatic wait_cap();
    int i;
    for (i = 0; i < 3000 && cap !== 1'b1; i++)
      @(posedge clk);
    if (i == 3000)
    begin
      n_mismatch++;
      $display("ERROR %0t: no capture", $time);
      close_out();
    end
  endtask : wait_cap

  // read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    rd_d <= rd;
    if (rd_d === 1'b1)
      chk(rdata, q.pop_front());
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    rd_d = 1'b0;
    go = 1'b0;
    gap = 8'h08;
    void'($urandom(32'h27C5B588));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rreg(TPIC_OFF_MODE, {29'h0, TPIC_MODE_RST});
    rreg(TPIC_OFF_IRQ_MASK, 32'h0);
    rreg(TPIC_OFF_STAT, 32'h0);
    rreg(8'h1C, 32'h0);
    wreg(TPIC_OFF_COUNT, 32'h0000_1234);
    rreg(TPIC_OFF_COUNT, 32'h0);
    wreg(TPIC_OFF_DATA, 32'h0000_00AB);
    rreg(TPIC_OFF_DATA, 32'h0000_00AB);
    wreg(TPIC_OFF_TRIG, 32'h1);
    rreg(TPIC_OFF_COUNT, 32'h0);
    rreg(TPIC_OFF_STAT, 32'h1);
    $display("test registers done");
    for (int m = 0; m < 4; m++)
    begin
      // gap of at least 8 lets the source stop before another edge lands
      gap <= 8'h08 + 8'($urandom % 16);
      wreg(TPIC_OFF_MODE, {30'h0, modes[m]});
      wreg(TPIC_OFF_IRQ_MASK, {31'h0, m != 0});
      wreg(TPIC_OFF_TRIG, 32'h1);
      go <= 1'b1;
      wait_cap();
      go <= 1'b0;
      @(posedge clk);
      chk(irq, {31'h0, m != 0});
      chk(cap, 32'h0);
      chk(en_st, 32'h1);
      // count cleared at the capture edge, two clocks later it reads two
      rreg(TPIC_OFF_COUNT, 32'h2);
      last = (modes[m] == TPIC_EDGE_BOTH) ? {24'h0, gap} - 1 : {23'h0, gap, 1'b0} - 1;
      rreg(TPIC_OFF_DATA, last);
      rreg(TPIC_OFF_IRQ_STAT, 32'h1);
      rreg(TPIC_OFF_STAT, 32'h1);
      wreg(TPIC_OFF_IRQ_STAT, 32'h1);
      @(posedge clk);
      chk(irq, 32'h0);
      $display("test edge mode %0d done", m);
    end
    wreg(TPIC_OFF_TRIG, 32'h2);
    rreg(TPIC_OFF_STAT, 32'h0);
    go <= 1'b1;
    repeat (200) @(posedge clk);
    go <= 1'b0;
    repeat (8) @(posedge clk);
    rreg(TPIC_OFF_DATA, last);
    chk(en_st, 32'h0);
    $display("test stop done");
    wreg(TPIC_OFF_MODE, 32'h5);
    wreg(TPIC_OFF_TRIG, 32'h4);
    rreg(TPIC_OFF_STAT, 32'h2);
    chk(up_st, 32'h1);
    wreg(TPIC_OFF_TRIG, 32'h8);
    rreg(TPIC_OFF_STAT, 32'h0);
    $display("test split done");
    @(posedge clk);
    close_out();
  end
endmodule : tb_timer_channel_pulse_interval_capture
